//--- hw/pab_pkg.sv
// package: register map, field positions and pin roles of the port a/b block
package pab_pkg;

  // register byte offsets
  localparam logic [7:0] PAB_OFF_PA_DATA = 8'h00;
  localparam logic [7:0] PAB_OFF_PB_DATA = 8'h04;
  localparam logic [7:0] PAB_OFF_PA_DIR  = 8'h08;
  localparam logic [7:0] PAB_OFF_PB_DIR  = 8'h0C;
  localparam logic [7:0] PAB_OFF_PA_PUE  = 8'h10;
  localparam logic [7:0] PAB_OFF_OSC     = 8'h14;

  // pull-up enable register layout
  localparam int         PAB_PUE_CLKOUT_BIT = 7;
  localparam logic [7:0] PAB_PUE_WR_MASK    = 8'hBF;

  // oscillator mode codes
  localparam logic [1:0] PAB_OSC_INT  = 2'h0;
  localparam logic [1:0] PAB_OSC_EXT  = 2'h1;
  localparam logic [1:0] PAB_OSC_XTAL = 2'h2;

  // reset values
  localparam logic [7:0] PAB_RST_PA_DATA = 8'h00;
  localparam logic [7:0] PAB_RST_DIR     = 8'h00;
  localparam logic [7:0] PAB_RST_PUE     = 8'h00;
  localparam logic [1:0] PAB_RST_OSC     = 2'h0;

  // port a pin roles
  localparam int PAB_PA_W        = 6;
  localparam int PAB_PIN_IN_ONLY = 2;
  localparam int PAB_PIN_CLK_OUT = 4;
  localparam int PAB_PIN_OSC_IN  = 5;

endpackage

//--- hw/pab_sync2.sv
// two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pab_sync2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

//--- hw/pab_port_ctrl.sv
// port a / port b pin control with apb register access
// Operation
// R1: pull-up enable bits 5..0 of port a are software read/write
// R2: pull-up on when its enable bit is 1 and direction is input
// R3: pull-up off whenever its enable bit is 0
// R4: direction 0 reads pin, direction 1 drives and reads latch
// R5: writing data to an input pin updates only the latch
// R6: enabled pull-up on an input pulls the pin high
// R7: port a pin 2 is never driven as an output
// R8: port b has eight pins each with its own data latch
// R9: port b data read/write, direction from port b direction register
// R10: reset leaves port b data latches unchanged
// R11: external clock mode keeps clock-out enable clear, pin 4 is plain io
// R12: crystal mode gives pin 4 to crystal, clock-out enable ignored
// R13: unused pull-up register bits read zero and ignore writes
`timescale 1ns/1ps
module pab_port_ctrl
  import pab_pkg::*;
#(
  parameter int PB_W = 8
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  // clock to show on pin 4
  input  wire logic                bus_clock_times_four,
  // port a pins
  input  wire logic [PAB_PA_W-1:0] porta_pin_in,
  output logic      [PAB_PA_W-1:0] porta_pin_out,
  output logic      [PAB_PA_W-1:0] porta_pin_oe,
  output logic      [PAB_PA_W-1:0] porta_pullup_on,
  // port b pins
  input  wire logic [PB_W-1:0]     portb_pin_in,
  output logic      [PB_W-1:0]     portb_pin_out,
  output logic      [PB_W-1:0]     portb_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  if (PB_W < 1 || PB_W > 8) begin : g_bad_width
    $error("port b width must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [PAB_PA_W-1:0] porta_data_latch;
  logic [PB_W-1:0]     portb_data_latch;
  logic [PAB_PA_W-1:0] porta_direction_bits;
  logic [PB_W-1:0]     portb_direction_bits;
  logic [7:0]          porta_pullup_enable_bits;
  logic [1:0]          osc_mode_reg;
  logic [PAB_PA_W-1:0] pa_sync;
  logic [PB_W-1:0]     pb_sync;
  logic                setup_cyc;
  logic                wr_take;
  logic                clk_out_active;
  logic [7:0]          rd_next;
  logic                hit_next;
  logic [PAB_PA_W-1:0] pa_oe_next;
  logic [PAB_PA_W-1:0] pa_out_next;
  logic [PAB_PA_W-1:0] pa_pu_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // pin level when input, latch when output
  function automatic logic [7:0] read_mux(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
    read_mux = (dir & latch) | (~dir & pin);
  endfunction

  // true when the bus address selects the given register
  function automatic logic is_reg(input logic [7:0] addr,
                                  input logic [7:0] off);
    is_reg = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  pab_sync2 #(
    .W (PAB_PA_W)
  ) u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (porta_pin_in),
    .q       (pa_sync)
  );

  pab_sync2 #(
    .W (PB_W)
  ) u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (portb_pin_in),
    .q       (pb_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait cycle, write lands at the pready edge
  assign setup_cyc = psel && penable && !pready;
  assign wr_take   = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_cyc;
    end
  end

  // read mux and address decode
  always_comb begin
    rd_next  = 8'h00;
    hit_next = 1'b1;
    if (is_reg(paddr, PAB_OFF_PA_DATA)) begin
      // zero-padded upper bits read back as zero
      rd_next = read_mux({2'b00, porta_direction_bits},
                         {2'b00, porta_data_latch},
                         {2'b00, pa_sync});         // [R4] [R5]
    end else if (is_reg(paddr, PAB_OFF_PB_DATA)) begin
      rd_next = read_mux(8'(portb_direction_bits),
                         8'(portb_data_latch),
                         8'(pb_sync));              // [R9]
    end else if (is_reg(paddr, PAB_OFF_PA_DIR)) begin
      rd_next[PAB_PA_W-1:0] = porta_direction_bits;  // [R4]
    end else if (is_reg(paddr, PAB_OFF_PB_DIR)) begin
      rd_next = 8'(portb_direction_bits);
    end else if (is_reg(paddr, PAB_OFF_PA_PUE)) begin
      rd_next = porta_pullup_enable_bits & PAB_PUE_WR_MASK; // [R13]
    end else if (is_reg(paddr, PAB_OFF_OSC)) begin
      rd_next[1:0] = osc_mode_reg;
    end else begin
      hit_next = 1'b0;
    end
  end

  // read data and error captured in the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_cyc) begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_next};
      pslverr <= !hit_next;
    end else begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // port a latch, written whatever the direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_data_latch <= PAB_RST_PA_DATA[PAB_PA_W-1:0];
    end else if (wr_take && is_reg(paddr, PAB_OFF_PA_DATA)) begin
      porta_data_latch <= pwdata[PAB_PA_W-1:0];  // [R5]
    end
  end

  // port b latch, untouched by reset
  always_ff @(posedge pclk) begin
    if (wr_take && is_reg(paddr, PAB_OFF_PB_DATA)) begin
      portb_data_latch <= pwdata[PB_W-1:0];      // [R8] [R9] [R10]
    end
  end

  // direction registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_direction_bits <= PAB_RST_DIR[PAB_PA_W-1:0];
      portb_direction_bits <= PAB_RST_DIR[PB_W-1:0];
    end else if (wr_take) begin
      if (is_reg(paddr, PAB_OFF_PA_DIR)) begin
        porta_direction_bits <= pwdata[PAB_PA_W-1:0]; // [R4]
      end
      if (is_reg(paddr, PAB_OFF_PB_DIR)) begin
        portb_direction_bits <= pwdata[PB_W-1:0];     // [R9]
      end
    end
  end

  // pull-up enable and clock-out enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_pullup_enable_bits <= PAB_RST_PUE;
    end else begin
      if (wr_take && is_reg(paddr, PAB_OFF_PA_PUE)) begin
        porta_pullup_enable_bits <= pwdata[7:0] & PAB_PUE_WR_MASK; // [R1] [R13]
      end
      if (osc_mode_reg == PAB_OSC_EXT) begin
        porta_pullup_enable_bits[PAB_PUE_CLKOUT_BIT] <= 1'b0; // [R11]
      end
    end
  end

  // oscillator mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_mode_reg <= PAB_RST_OSC;
    end else if (wr_take && is_reg(paddr, PAB_OFF_OSC)) begin
      osc_mode_reg <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  // clock-out only counts in internal mode
  assign clk_out_active = porta_pullup_enable_bits[PAB_PUE_CLKOUT_BIT]
                          && (osc_mode_reg == PAB_OSC_INT); // [R12]

  always_comb begin
    pa_oe_next  = porta_direction_bits;              // [R4]
    pa_out_next = porta_data_latch;
    pa_pu_next  = porta_pullup_enable_bits[PAB_PA_W-1:0]
                  & ~porta_direction_bits;           // [R2] [R3] [R6]
    pa_oe_next[PAB_PIN_IN_ONLY] = 1'b0;              // [R7]
    if (clk_out_active) begin
      pa_oe_next[PAB_PIN_CLK_OUT]  = 1'b1;
      pa_out_next[PAB_PIN_CLK_OUT] = bus_clock_times_four;
      pa_pu_next[PAB_PIN_CLK_OUT]  = 1'b0;
    end
    if (osc_mode_reg == PAB_OSC_XTAL) begin
      pa_oe_next[PAB_PIN_CLK_OUT] = 1'b0;            // [R12]
      pa_pu_next[PAB_PIN_CLK_OUT] = 1'b0;
    end
    if (osc_mode_reg != PAB_OSC_INT) begin
      pa_oe_next[PAB_PIN_OSC_IN] = 1'b0;
      pa_pu_next[PAB_PIN_OSC_IN] = 1'b0;
    end
  end

  // registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_pin_out   <= '0;
      porta_pin_oe    <= '0;
      porta_pullup_on <= '0;
    end else begin
      porta_pin_out   <= pa_out_next;
      porta_pin_oe    <= pa_oe_next;
      porta_pullup_on <= pa_pu_next;
    end
  end

  // port b latch may be unknown after reset, so gate it with its direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portb_pin_out <= '0;
      portb_pin_oe  <= '0;
    end else begin
      portb_pin_out <= portb_data_latch & portb_direction_bits; // [R8]
      portb_pin_oe  <= portb_direction_bits;                    // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pue_write;
    wr_take && is_reg(paddr, PAB_OFF_PA_PUE)
    |=> porta_pullup_enable_bits[5:0] == $past(pwdata[5:0]);
  endproperty
  a_pue_write: assert property (p_pue_write) // [R1]
    else $error("pull-up enable bits not written");

  property p_pullup_on;
    ##1 porta_pullup_on[0] == $past(porta_pullup_enable_bits[0]
                                    && !porta_direction_bits[0]);
  endproperty
  a_pullup_on: assert property (p_pullup_on) // [R2]
    else $error("pull-up on pin 0 wrong");

  property p_pullup_off;
    !porta_pullup_enable_bits[3] |=> !porta_pullup_on[3];
  endproperty
  a_pullup_off: assert property (p_pullup_off) // [R3]
    else $error("pull-up on with enable clear");

  property p_read_latch;
    setup_cyc && !pwrite && is_reg(paddr, PAB_OFF_PA_DATA)
      && porta_direction_bits[1]
    |=> prdata[1] == $past(porta_data_latch[1]) && pready;
  endproperty
  a_read_latch: assert property (p_read_latch) // [R4]
    else $error("output pin read did not return latch");

  property p_input_write;
    wr_take && is_reg(paddr, PAB_OFF_PA_DATA) && !porta_direction_bits[0]
    |=> porta_data_latch[0] == $past(pwdata[0]) && !porta_pin_oe[0];
  endproperty
  a_input_write: assert property (p_input_write) // [R5]
    else $error("input write drove pin or missed latch");

  property p_pin2_never;
    !porta_pin_oe[PAB_PIN_IN_ONLY];
  endproperty
  a_pin2_never: assert property (p_pin2_never) // [R7]
    else $error("pin 2 driven");

  property p_pb_write;
    wr_take && is_reg(paddr, PAB_OFF_PB_DATA)
    |=> portb_data_latch == $past(pwdata[PB_W-1:0]);
  endproperty
  a_pb_write: assert property (p_pb_write) // [R9]
    else $error("port b latch not written");

  property p_ext_clear;
    osc_mode_reg == PAB_OSC_EXT [*2]
    |-> !porta_pullup_enable_bits[PAB_PUE_CLKOUT_BIT];
  endproperty
  a_ext_clear: assert property (p_ext_clear) // [R11]
    else $error("clock-out enable set in external mode");

  property p_xtal_pin4;
    osc_mode_reg == PAB_OSC_XTAL |=> !porta_pin_oe[PAB_PIN_CLK_OUT];
  endproperty
  a_xtal_pin4: assert property (p_xtal_pin4) // [R12]
    else $error("pin 4 driven in crystal mode");

  property p_xtal_pu4;
    osc_mode_reg == PAB_OSC_XTAL |=> !porta_pullup_on[PAB_PIN_CLK_OUT];
  endproperty
  a_xtal_pu4: assert property (p_xtal_pu4) // [R12]
    else $error("pin 4 pull-up on in crystal mode");

  property p_bit6_zero;
    setup_cyc && !pwrite && is_reg(paddr, PAB_OFF_PA_PUE)
    |=> prdata[6] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) // [R13]
    else $error("unused pull-up bit read nonzero");

endmodule

//--- testbench/pab_board.sv
// board model: resolves port pin levels from device drive, board drive and pull-ups
`timescale 1ns/1ps
module pab_board
  import pab_pkg::*;
(
  // port a side
  input  wire logic [PAB_PA_W-1:0] pa_out,
  input  wire logic [PAB_PA_W-1:0] pa_oe,
  input  wire logic [PAB_PA_W-1:0] pa_pu,
  input  wire logic [PAB_PA_W-1:0] pa_ext,
  input  wire logic [PAB_PA_W-1:0] pa_ext_en,
  output logic      [PAB_PA_W-1:0] pa_pin,
  // port b side
  input  wire logic [7:0]          pb_out,
  input  wire logic [7:0]          pb_oe,
  input  wire logic [7:0]          pb_ext,
  output logic      [7:0]          pb_pin
);
  // device drive wins, then board, then pull-up; a floating pin shows the inverse of pa_ext
  always_comb begin
    for (int i = 0; i < PAB_PA_W; i++) begin
      if (pa_oe[i]) pa_pin[i] = pa_out[i];
      else if (pa_ext_en[i]) pa_pin[i] = pa_ext[i];
      else if (pa_pu[i]) pa_pin[i] = 1'b1;
      else pa_pin[i] = ~pa_ext[i];
    end
    for (int j = 0; j < 8; j++) begin
      pb_pin[j] = pb_oe[j] ? pb_out[j] : pb_ext[j];
    end
  end
endmodule

//--- testbench/pab_port_ctrl_tb.sv
// self-checking bench for the port a/b pin control block
`timescale 1ns/1ps
module pab_port_ctrl_tb
  import pab_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, bck4, er;
  logic [7:0]  paddr, pb_oe, pb_out, pb_pin, pb_ext;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pa_out, pa_oe, pa_pu, pa_pin, pa_ext, pa_ext_en;
  int          mismatches, total_checks;
  // table rows: address, written value, value read back
  logic [7:0]  row_a [6] = '{PAB_OFF_PA_DIR, PAB_OFF_PB_DIR, PAB_OFF_PA_DATA,
                             PAB_OFF_PB_DATA, PAB_OFF_PA_PUE, PAB_OFF_PA_PUE};
  logic [7:0]  row_w [6] = '{8'h3F, 8'hFF, 8'h2A, 8'h5A, 8'hFF, 8'h40};
  logic [7:0]  row_e [6] = '{8'h3F, 8'hFF, 8'h2A, 8'h5A, 8'hBF, 8'h00};

  pab_port_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bus_clock_times_four(bck4), .porta_pin_in(pa_pin),
    .porta_pin_out(pa_out), .porta_pin_oe(pa_oe), .porta_pullup_on(pa_pu),
    .portb_pin_in(pb_pin), .portb_pin_out(pb_out), .portb_pin_oe(pb_oe));

  pab_board i_board (.pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu), .pa_ext(pa_ext),
    .pa_ext_en(pa_ext_en), .pa_pin(pa_pin), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_ext(pb_ext), .pb_pin(pb_pin));

  // clock and a fast level for the clock-out pin
  always #4 pclk = ~pclk;
  always @(posedge pclk or negedge presetn) bck4 <= presetn ? ~bck4 : 1'b0;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, exp}, rd);
    chk("pslverr", 0, er);
  endtask

  // pin sync latency plus output register
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #50000;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    results();
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    pa_ext = 0; pa_ext_en = 0; pb_ext = 8'hA5; mismatches = 0; total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("pa_oe", 0, pa_oe);
    chk("pa_pu", 0, pa_pu);
    rdc("pa_dir", PAB_OFF_PA_DIR, 8'h00);
    done("reset");
    foreach (row_a[i]) begin
      wr(row_a[i], row_w[i]);
      rdc("row", row_a[i], row_e[i]);
    end
    settle();
    chk("pa_oe", 8'h3B, pa_oe);
    chk("pa_out", 8'h2A & 8'h3B, pa_out & pa_oe);
    chk("pb_out", 8'h5A, pb_out);
    done("rows");
    // input pins read the pin, writes only reach the latch
    wr(PAB_OFF_PA_DIR, 8'h00);
    wr(PAB_OFF_PA_DATA, 8'h15);
    pa_ext <= 6'h2C;
    pa_ext_en <= 6'h3F;
    settle();
    rdc("pa_in", PAB_OFF_PA_DATA, 8'h2C);
    wr(PAB_OFF_PA_DIR, 8'h3F);
    rdc("pa_latch", PAB_OFF_PA_DATA, 8'h15);
    done("input");
    // pull-ups
    wr(PAB_OFF_PA_DIR, 8'h00);
    pa_ext_en <= 6'h00;
    wr(PAB_OFF_PA_PUE, 8'h3F);
    settle();
    chk("pa_pu", 8'h3F, pa_pu);
    rdc("pa_pulled", PAB_OFF_PA_DATA, 8'h3F);
    wr(PAB_OFF_PA_DIR, 8'h0F);
    settle();
    chk("pa_pu", 8'h30, pa_pu);
    wr(PAB_OFF_PA_PUE, 8'h00);
    wr(PAB_OFF_PA_DIR, 8'h00);
    settle();
    chk("pa_pu", 0, pa_pu);
    done("pullup");
    // oscillator modes and the clock-out pin
    wr(PAB_OFF_PA_PUE, 8'h80);
    settle();
    chk("clk_oe", 1, pa_oe[PAB_PIN_CLK_OUT]);
    // clock-out pin follows the toggling clock level edge by edge
    rd[0] = pa_out[PAB_PIN_CLK_OUT];
    @(posedge pclk);
    chk("clk_out", {31'h0, ~rd[0]}, pa_out[PAB_PIN_CLK_OUT]);
    wr(PAB_OFF_OSC, {6'h0, PAB_OSC_EXT});
    settle();
    rdc("pue_ext", PAB_OFF_PA_PUE, 8'h00);
    chk("pa_oe", 0, pa_oe);
    wr(PAB_OFF_PA_PUE, 8'h80);
    rdc("pue_ext", PAB_OFF_PA_PUE, 8'h00);
    wr(PAB_OFF_OSC, {6'h0, PAB_OSC_XTAL});
    wr(PAB_OFF_PA_PUE, 8'hBF);
    settle();
    rdc("pue_xtal", PAB_OFF_PA_PUE, 8'hBF);
    chk("pa_pu", 8'h0F, pa_pu);
    chk("pa_oe", 0, pa_oe);
    done("osc");
    // unmapped address is refused
    wr(8'h18, 8'h55);
    chk("err_wr", 1, er);
    apb(1'b0, 8'h18, 8'h00);
    chk("err_rd", 1, er);
    chk("err_data", 0, rd);
    done("unmapped");
    // port b mixed directions, then latches kept over reset
    wr(PAB_OFF_PB_DIR, 8'h0F);
    wr(PAB_OFF_PB_DATA, 8'h3C);
    settle();
    rdc("pb_mix", PAB_OFF_PB_DATA, 8'hAC);
    chk("pb_oe", 8'h0F, pb_oe);
    chk("pb_out", 8'h0C, pb_out);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("pb_oe_rst", 0, pb_oe);
    wr(PAB_OFF_PB_DIR, 8'hFF);
    rdc("pb_kept", PAB_OFF_PB_DATA, 8'h3C);
    done("portb");
    results();
  end
endmodule
